//--- logic/spc_consts.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPC_CONSTS_SVH
`define SPC_CONSTS_SVH

// register byte offsets on the apb bus
`define SPC_OFF_CTRL1   8'h00
`define SPC_OFF_CTRL2   8'h04
`define SPC_OFF_STAT    8'h08
`define SPC_OFF_DATA    8'h0c
`define SPC_OFF_EVT     8'h10
`define SPC_OFF_MASK    8'h14

// serial_port_control_one field positions
`define SPC_C1_RFIE     7
`define SPC_C1_EN       6
`define SPC_C1_TIE      5
`define SPC_C1_ROLE     4
`define SPC_C1_CLOCK_POLARITY     3
`define SPC_C1_CLOCK_PHASE     2
`define SPC_C1_SELECT_OUTPUT_ENABLE     1
`define SPC_C1_LSBF     0

// second control register field positions
`define SPC_C2_MODE_FAULT_ENABLE   4
`define SPC_C2_BIDIR    3
`define SPC_C2_SWIRE    0

// status register field positions
`define SPC_ST_RXF      7
`define SPC_ST_TXE      5
`define SPC_ST_FLT      4

// event register field positions
`define SPC_EV_DONE     0
`define SPC_EV_FLT      1
`define SPC_EV_TXE      2

// reset values
`define SPC_CTRL1_RST   8'h04
`define SPC_CTRL2_RST   8'h00

// pclk cycles per half serial clock period in master role; at least 6,
// since returned data must cross the pin filter before the sample edge
`define SPC_HALF_DEF    8
// index of the last serial clock edge in one byte
`define SPC_LAST_EDGE   4'hf

`endif

//--- logic/spc_pkg.sv
// types shared by the serial port control logic
package spc_pkg;

	// transfer engine states
	typedef enum logic [1:0] {
		st_idle,
		st_run,
		st_tail,
		st_gap
	} spc_state_t;

endpackage : spc_pkg

//--- logic/spc_sync3.sv
// three-stage synchroniser bank for pin inputs with agreement filter
`timescale 1ns/100ps
module spc_sync3
	import spc_pkg::*;
	#(
	parameter int           W       = 4,
	parameter logic [W-1:0] RST_VAL = '0
	)
	(
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	// raw pins and filtered levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
	);

	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		logic [2:0] s_q;  // three capture stages
		// stage 0 feeds stage 1 only; output moves once stages 1 and 2 agree
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s_q    <= {3{RST_VAL[i]}};
				q_o[i] <= RST_VAL[i];
			end else if (clk_en) begin
				s_q <= {s_q[1:0], d_i[i]};
				if (s_q[1] == s_q[2]) begin
					q_o[i] <= s_q[2];
				end
			end
		end
	end

endmodule : spc_sync3

//--- logic/spc_ctrl_top.sv
// serial port pin steering, control registers and byte transfer engine
//
// Overview of operation
// - disabled interface releases all four pins
// - clock pin input as slave, output master
// - two-wire: master-out drives master, samples slave
// - single-wire master: master-out direction follows bidir enable
// - single-wire slave: master-out pin released
// - two-wire: master-in samples master, drives selected slave
// - single-wire slave: master-in direction follows bidir enable
// - single-wire master: master-in pin released
// - slave uses select pin, active low input
// - master without fault enable releases select
// - master fault enable: fault input or select output
// - receive/fault interrupt gated by its enable
// - disable aborts, empties buffers, resets full and empty flags
// - transmit-empty interrupt gated by its enable
// - role bit: one master, zero slave
// - polarity bit sets clock idle level
// - phase bit places first sample edge
`timescale 1ns/100ps
`include "spc_consts.svh"
module spc_ctrl_top
	import spc_pkg::*;
	#(
	parameter int HALF_DIV = `SPC_HALF_DEF
	)
	(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial clock pin
	input  wire logic        serial_clock_pin_i,
	output logic             serial_clock_pin_o,
	output logic             serial_clock_pin_oe,
	output logic             serial_clock_pin_own,
	// master-out pin
	input  wire logic        master_out_pin_i,
	output logic             master_out_pin_o,
	output logic             master_out_pin_oe,
	output logic             master_out_pin_own,
	// master-in pin
	input  wire logic        master_in_pin_i,
	output logic             master_in_pin_o,
	output logic             master_in_pin_oe,
	output logic             master_in_pin_own,
	// slave select pin
	input  wire logic        slave_select_pin_n_i,
	output logic             slave_select_pin_n_o,
	output logic             slave_select_pin_oe,
	output logic             slave_select_pin_own,
	// interrupt
	output logic             irq
	);

	// bit pick and shift for either bit order
	function automatic logic pick_bit(input logic [7:0] sh, input logic lsb);
		pick_bit = lsb ? sh[0] : sh[7];
	endfunction : pick_bit

	function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
		input logic lsb);
		shift_in = lsb ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction : shift_in

	// mapped register check, used for the error response
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `SPC_OFF_CTRL1) || (a == `SPC_OFF_CTRL2) || (a == `SPC_OFF_STAT)
			|| (a == `SPC_OFF_DATA) || (a == `SPC_OFF_EVT) || (a == `SPC_OFF_MASK);
	endfunction : addr_ok

	// registers
	logic [7:0]  ctrl1_q;          // serial_port_control_one
	logic [7:0]  ctrl2_q;          // second control register
	logic [7:0]  tx_buf_q;         // transmit buffer
	logic [7:0]  rx_buf_q;         // receive buffer
	logic [7:0]  tx_sh_q;          // outgoing shifter
	logic [7:0]  rx_sh_q;          // incoming shifter
	logic [7:0]  rx_nx;            // incoming shifter after this edge
	logic        rx_full_q;        // receive_full_flag
	logic        tx_empty_q;       // transmit_empty_flag
	logic        fault_q;          // mode_fault_flag
	logic [2:0]  evt_q;            // sticky events
	logic [2:0]  mask_q;           // event mask
	spc_state_t  state_q;          // engine state
	logic [3:0]  edge_cnt_q;       // clock edge index in byte
	logic [15:0] div_q;            // half period divider
	logic        sclk_q;           // master clock level
	logic        ss_out_q;         // master select level
	logic        sclk_prev_q;      // last filtered clock level
	logic [31:0] rd_mux;           // read data selection
	logic [3:0]  pin_s;            // filtered pin levels
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic        irq_q;
	logic        sclk_o_q, sclk_oe_q, sclk_own_q;
	logic        mosi_o_q, mosi_oe_q, mosi_own_q;
	logic        miso_o_q, miso_oe_q, miso_own_q;
	logic        ss_o_q, ss_oe_q, ss_own_q;

	// pin input filter: clock, master-out, master-in, select (idle high)
	spc_sync3 #(.W(4), .RST_VAL(4'h8)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.d_i     ({slave_select_pin_n_i, master_in_pin_i, master_out_pin_i,
			serial_clock_pin_i}),
		.q_o     (pin_s)
	);

	// decoded control fields
	wire en      = ctrl1_q[`SPC_C1_EN];
	wire role_select    = ctrl1_q[`SPC_C1_ROLE];
	wire clock_polarity    = ctrl1_q[`SPC_C1_CLOCK_POLARITY];
	wire clock_phase    = ctrl1_q[`SPC_C1_CLOCK_PHASE];
	wire select_output_enable    = ctrl1_q[`SPC_C1_SELECT_OUTPUT_ENABLE];
	wire lsb     = ctrl1_q[`SPC_C1_LSBF];
	wire mode_fault_enable  = ctrl2_q[`SPC_C2_MODE_FAULT_ENABLE];
	wire bidir   = ctrl2_q[`SPC_C2_BIDIR];
	wire swire   = ctrl2_q[`SPC_C2_SWIRE];

	// roles and pin-derived conditions
	wire master    = en & role_select;
	wire slave     = en & !role_select;
	wire selected  = slave & !pin_s[3];
	wire fault_det = master & mode_fault_enable & !select_output_enable & !pin_s[3];
	wire din       = master ? (swire ? pin_s[1] : pin_s[2])
		: (swire ? pin_s[2] : pin_s[1]);
	wire out_bit   = pick_bit(tx_sh_q, lsb);

	// edge scheduling within the byte
	wire tick      = (div_q == 16'(HALF_DIV - 1));
	wire sl_edge   = pin_s[0] ^ sclk_prev_q;
	wire do_sample = (edge_cnt_q[0] == clock_phase);
	// slave steps on as soon as it samples: filter delay would miss the next far sample
	wire do_shift  = master ? (!do_sample && !(clock_phase && (edge_cnt_q == 4'h0)))
		: do_sample;
	wire start_m   = master & (state_q == st_idle) & !tx_empty_q & !fault_det;
	wire start_s   = slave & (state_q == st_idle) & selected;
	wire edge_m    = master & (state_q == st_run) & tick;
	wire edge_s    = slave & (state_q == st_run) & selected & sl_edge;
	wire edge_ev   = edge_m | edge_s;
	wire last_edge = edge_ev & (edge_cnt_q == `SPC_LAST_EDGE);
	wire done_m    = master & (state_q == st_tail) & tick;
	wire done_s    = slave & last_edge;
	wire byte_done = done_m | done_s;
	wire load      = start_m | start_s;
	wire abort     = !en | fault_det | (slave & (state_q == st_run) & !selected);

	// apb access phase strobes
	wire acc     = psel & penable & pready_q;
	wire wr      = acc & pwrite;
	wire rd_data = acc & !pwrite & (paddr == `SPC_OFF_DATA);

	// incoming shifter value after the current edge
	always_comb begin
		rx_nx = rx_sh_q;
		if (edge_ev && do_sample) begin
			rx_nx = shift_in(rx_sh_q, din, lsb);
		end
	end

	// read data selection
	always_comb begin
		rd_mux = 32'h0;
		case (paddr)
			`SPC_OFF_CTRL1: rd_mux = {24'h0, ctrl1_q};
			`SPC_OFF_CTRL2: rd_mux = {24'h0, ctrl2_q};
			`SPC_OFF_STAT:  rd_mux = {24'h0, rx_full_q, 1'b0, tx_empty_q, fault_q, 4'h0};
			`SPC_OFF_DATA:  rd_mux = {24'h0, rx_buf_q};
			`SPC_OFF_EVT:   rd_mux = {29'h0, evt_q};
			`SPC_OFF_MASK:  rd_mux = {29'h0, mask_q};
			default:        rd_mux = 32'h0;
		endcase
	end

	// apb answer: one wait-free access phase after each setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else if (clk_en) begin
			pready_q  <= psel & !penable;
			pslverr_q <= psel & !penable & !addr_ok(paddr);
			prdata_q  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// control registers; a mode fault drops the master role
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl1_q <= `SPC_CTRL1_RST;
			ctrl2_q <= `SPC_CTRL2_RST;
			mask_q  <= 3'h0;
		end else if (clk_en) begin
			if (wr && paddr == `SPC_OFF_CTRL1) begin
				ctrl1_q <= pwdata[7:0];
			end
			if (wr && paddr == `SPC_OFF_CTRL2) begin
				ctrl2_q <= pwdata[7:0] & 8'h19;
			end
			if (wr && paddr == `SPC_OFF_MASK) begin
				mask_q <= pwdata[2:0];
			end
			if (fault_det) begin
				ctrl1_q[`SPC_C1_ROLE] <= 1'b0;  // fault overrides a same-cycle write
			end
		end
	end

	// data buffers; disabling empties both
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_buf_q <= 8'h0;
			rx_buf_q <= 8'h0;
		end else if (clk_en) begin
			if (!en) begin
				tx_buf_q <= 8'h0;
				rx_buf_q <= 8'h0;
			end else begin
				if (wr && paddr == `SPC_OFF_DATA) begin
					tx_buf_q <= pwdata[7:0];
				end
				if (byte_done) begin
					rx_buf_q <= rx_nx;
				end
			end
		end
	end

	// status flags; hardware set wins over software clear for receive full and fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_full_q  <= 1'b0;
			tx_empty_q <= 1'b1;
			fault_q    <= 1'b0;
		end else if (clk_en) begin
			if (!en) begin
				rx_full_q  <= 1'b0;
				tx_empty_q <= 1'b1;
			end else begin
				// receive full: byte completion beats a data read
				if (byte_done) begin
					rx_full_q <= 1'b1;
				end else if (rd_data) begin
					rx_full_q <= 1'b0;
				end
				// transmit empty: a new write means the buffer holds data
				if (wr && paddr == `SPC_OFF_DATA) begin
					tx_empty_q <= 1'b0;
				end else if (load) begin
					tx_empty_q <= 1'b1;
				end
			end
			// mode fault flag, cleared by writing one
			if (fault_det) begin
				fault_q <= 1'b1;
			end else if (wr && paddr == `SPC_OFF_STAT && pwdata[`SPC_ST_FLT]) begin
				fault_q <= 1'b0;
			end
		end
	end

	// sticky events, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= 3'h0;
		end else if (clk_en) begin
			evt_q <= (evt_q & ~((wr && paddr == `SPC_OFF_EVT) ? pwdata[2:0] : 3'h0))
				| {load, fault_det, byte_done};
		end
	end

	// interrupt output: flag enables plus masked sticky events
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_q <= (ctrl1_q[`SPC_C1_RFIE] & (rx_full_q | fault_q))
				| (ctrl1_q[`SPC_C1_TIE] & tx_empty_q)
				| (|(evt_q & mask_q));
		end
	end

	// transfer engine: state, divider, edge count, clock and select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= st_idle;
			div_q       <= 16'h0;
			edge_cnt_q  <= 4'h0;
			sclk_q      <= 1'b0;
			ss_out_q    <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			sclk_prev_q <= pin_s[0];
			div_q       <= (tick || state_q == st_idle) ? 16'h0 : div_q + 16'h1;
			if (abort) begin
				state_q    <= st_idle;
				edge_cnt_q <= 4'h0;
				sclk_q     <= clock_polarity;
				ss_out_q   <= 1'b1;
			end else begin
				case (state_q)
					st_idle: begin
						sclk_q     <= clock_polarity;
						edge_cnt_q <= 4'h0;
						if (load) begin
							state_q  <= st_run;
							ss_out_q <= !master;
						end
					end
					st_run: begin
						if (edge_ev) begin
							edge_cnt_q <= edge_cnt_q + 4'h1;
							sclk_q     <= master ? !sclk_q : sclk_q;
							if (last_edge) begin
								state_q <= master ? st_tail : st_idle;
							end
						end
					end
					st_tail: begin
						if (tick) begin
							state_q  <= st_gap;
							ss_out_q <= 1'b1;
						end
					end
					st_gap: begin
						if (tick) begin
							state_q <= st_idle;
						end
					end
					default: state_q <= st_idle;
				endcase
			end
		end
	end

	// shifters: load from buffer, shift and sample on scheduled edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_q <= 8'h0;
			rx_sh_q <= 8'h0;
		end else if (clk_en) begin
			if (abort) begin
				tx_sh_q <= 8'h0;
				rx_sh_q <= 8'h0;
			end else if (load) begin
				tx_sh_q <= tx_buf_q;
				rx_sh_q <= 8'h0;
			end else begin
				rx_sh_q <= rx_nx;
				if (edge_ev && do_shift) begin
					tx_sh_q <= lsb ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
				end
			end
		end
	end

	// pin steering, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_own_q <= 1'b0;
			sclk_oe_q  <= 1'b0;
			sclk_o_q   <= 1'b0;
			mosi_own_q <= 1'b0;
			mosi_oe_q  <= 1'b0;
			mosi_o_q   <= 1'b0;
			miso_own_q <= 1'b0;
			miso_oe_q  <= 1'b0;
			miso_o_q   <= 1'b0;
			ss_own_q   <= 1'b0;
			ss_oe_q    <= 1'b0;
			ss_o_q     <= 1'b1;
		end else if (clk_en) begin
			// serial clock: input as slave, output as master
			sclk_own_q <= en;
			sclk_oe_q  <= master;
			sclk_o_q   <= sclk_q;
			// master-out: two-wire per role, single-wire master only
			mosi_own_q <= en & (!swire | role_select);
			mosi_oe_q  <= master & (!swire | bidir);
			mosi_o_q   <= out_bit;
			// master-in: two-wire per role, single-wire slave only
			miso_own_q <= en & (!swire | !role_select);
			miso_oe_q  <= slave & (swire ? bidir : selected);
			miso_o_q   <= out_bit;
			// select: slave input, master fault input or output
			ss_own_q   <= en & (!role_select | mode_fault_enable);
			ss_oe_q    <= master & mode_fault_enable & select_output_enable;
			ss_o_q     <= ss_out_q;
		end
	end

	// output ports
	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign irq                  = irq_q;
	assign serial_clock_pin_o   = sclk_o_q;
	assign serial_clock_pin_oe  = sclk_oe_q;
	assign serial_clock_pin_own = sclk_own_q;
	assign master_out_pin_o     = mosi_o_q;
	assign master_out_pin_oe    = mosi_oe_q;
	assign master_out_pin_own   = mosi_own_q;
	assign master_in_pin_o      = miso_o_q;
	assign master_in_pin_oe     = miso_oe_q;
	assign master_in_pin_own    = miso_own_q;
	assign slave_select_pin_n_o = ss_o_q;
	assign slave_select_pin_oe  = ss_oe_q;
	assign slave_select_pin_own = ss_own_q;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	pins_release_a: assert property (clk_en && !en |=> !sclk_own_q && !mosi_own_q
		&& !miso_own_q && !ss_own_q && !sclk_oe_q && !mosi_oe_q && !miso_oe_q && !ss_oe_q)
		else $error("pins not released while disabled");
	clock_dir_a: assert property (clk_en && en |=> sclk_own_q && sclk_oe_q == $past(role_select))
		else $error("serial clock direction wrong for role");
	mosi_two_a: assert property (clk_en && en && !swire |=> mosi_own_q
		&& mosi_oe_q == $past(role_select)) else $error("master-out two-wire use wrong");
	mosi_shared_a: assert property (clk_en && master && swire |=> mosi_oe_q == $past(bidir))
		else $error("shared master pin direction wrong");
	mosi_free_a: assert property (clk_en && slave && swire |=> !mosi_own_q)
		else $error("master-out not released in single-wire slave");
	miso_two_a: assert property (clk_en && master && !swire |=> miso_own_q && !miso_oe_q)
		else $error("master-in must be input for master");
	miso_shared_a: assert property (clk_en && slave && swire |=> miso_oe_q == $past(bidir))
		else $error("shared slave pin direction wrong");
	miso_free_a: assert property (clk_en && master && swire |=> !miso_own_q)
		else $error("master-in not released in single-wire master");
	select_free_a: assert property (clk_en && master && !mode_fault_enable |=> !ss_own_q)
		else $error("select pin not released");
	select_out_a: assert property (clk_en && master && mode_fault_enable |=> ss_own_q
		&& ss_oe_q == $past(select_output_enable)) else $error("select direction wrong");
	rx_irq_a: assert property (clk_en && ctrl1_q[`SPC_C1_RFIE] && fault_q |=> irq_q)
		else $error("fault interrupt missing");
	flush_a: assert property (clk_en && !en |=> !rx_full_q && tx_empty_q
		&& state_q == st_idle) else $error("disable did not flush");
	tx_irq_a: assert property (clk_en && ctrl1_q[`SPC_C1_TIE] && tx_empty_q |=> irq_q)
		else $error("transmit interrupt missing");
	clock_idle_a: assert property (clk_en && state_q == st_idle && !abort
		##1 clk_en |=> sclk_o_q == $past(clock_polarity, 2)) else $error("clock idle level wrong");

	master_byte_c: cover property (done_m);
	slave_byte_c:  cover property (done_s);
	fault_c:       cover property (fault_det);
	irq_c:         cover property ($rose(irq_q));

endmodule : spc_ctrl_top

//--- sim/spc_far_slave.sv
// behavioural far-end slave device for the master-role byte traffic
`timescale 1ns/100ps
module spc_far_slave
	import spc_pkg::*;
	(
	// clock format
	input  wire logic       clock_polarity,
	input  wire logic       clock_phase,
	// link pins
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	// byte sent and byte taken
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic      [7:0] rx_byte
	);
	int k; // bits put out so far
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
	end
	// select low loads the byte; phase zero shows the first bit at once
	always @(negedge ss_n) begin
		k = 0;
		if (!clock_phase) begin
			miso = tx_byte[7];
			k = 1;
		end
	end
	// a released line shows the inverse of its last bit, not a held value
	always @(posedge ss_n) miso = ~miso;
	// leading or trailing edge samples, the other shifts out
	always @(sck) if (!ss_n) begin
		if ((sck != clock_polarity) ^ clock_phase) begin
			rx_byte = {rx_byte[6:0], mosi};
		end else if (k < 8) begin
			miso = tx_byte[7 - k];
			k = k + 1;
		end
	end
endmodule : spc_far_slave

//--- sim/spi_pin_control_and_config_tb_top.sv
// testbench: registers, pin steering, interrupts and byte traffic of the serial port
`timescale 1ns/100ps
`include "spc_consts.svh"
module spi_pin_control_and_config_tb_top
	import spc_pkg::*;
	;
	logic        pclk = 1'b0;            // bus clock
	logic        presetn = 1'b0;         // reset, active low
	logic        psel = 1'b0;            // apb request
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;             // apb answer
	logic        pready, pslverr, err, irq;
	logic        sck_o, sck_oe, sck_own, mo_o, mo_oe, mo_own;
	logic        mi_o, mi_oe, mi_own, ssn_o, ss_oe, ss_own;
	logic        tb_sck = 1'b0;          // far master pins
	logic        tb_mosi = 1'b0;
	logic        tb_ss_n = 1'b1;
	logic        clock_phase = 1'b0;
	logic        far_miso;
	logic [7:0]  far_tx = 8'h3c, far_rx, sl_rx;
	logic [23:0] cfg [9];                // ctrl1, ctrl2, expected own/oe pairs
	int          n_errors = 0;
	int          n_checks = 0;
	// wire levels from all drivers; a released select follows tb_ss_n
	wire         sck_w = sck_oe ? sck_o : tb_sck;
	wire         mosi_w = mo_oe ? mo_o : tb_mosi;
	wire         miso_w = mi_oe ? mi_o : far_miso;
	wire         ss_w = ss_oe ? ssn_o : tb_ss_n;
	wire  [7:0]  pins = {sck_own, sck_oe, mo_own, mo_oe, mi_own, mi_oe, ss_own, ss_oe};
	always #10 pclk = ~pclk;
	spc_ctrl_top dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_w),
		.serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .serial_clock_pin_own(sck_own),
		.master_out_pin_i(mosi_w), .master_out_pin_o(mo_o), .master_out_pin_oe(mo_oe),
		.master_out_pin_own(mo_own), .master_in_pin_i(miso_w), .master_in_pin_o(mi_o),
		.master_in_pin_oe(mi_oe), .master_in_pin_own(mi_own), .slave_select_pin_n_i(ss_w),
		.slave_select_pin_n_o(ssn_o), .slave_select_pin_oe(ss_oe),
		.slave_select_pin_own(ss_own), .irq(irq));
	spc_far_slave far (.clock_polarity(1'b0), .clock_phase(clock_phase), .sck(sck_w), .mosi(mosi_w), .ss_n(ss_w),
		.tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle cycle keeps the next setup off the release edge
		@(posedge pclk);
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h0, e});
	endtask : rchk
	task automatic wirq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		chk(irq, 1'b1);
	endtask : wirq
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// hang guard
	initial begin
		tick(20000);
		n_errors++;
		test_done();
	end
	initial begin
		cfg = '{24'h040000, 24'h5000f8, 24'h5010fa, 24'h5210fb, 24'h5001e0, 24'h5009f0,
			24'h4000aa, 24'h40018a, 24'h40098e};
		tick(2);
		presetn <= 1'b1;
		tick(1);
		rchk(`SPC_OFF_CTRL1, `SPC_CTRL1_RST);
		rchk(`SPC_OFF_STAT, 8'h20);
		rchk(8'h18, 8'h00);
		chk(err, 1'b1);
		// pin ownership and direction over every role and wire mode
		foreach (cfg[i]) begin
			apb(1'b1, `SPC_OFF_CTRL2, cfg[i][15:8]);
			apb(1'b1, `SPC_OFF_CTRL1, cfg[i][23:16]);
			tick(3);
			chk(pins, cfg[i][7:0]);
		end
		// select driven low by the far side while it is the fault input
		apb(1'b1, `SPC_OFF_CTRL2, 8'h10);
		apb(1'b1, `SPC_OFF_CTRL1, 8'hd0);
		tb_ss_n <= 1'b0;
		tick(8);
		rchk(`SPC_OFF_STAT, 8'h30);
		chk(irq, 1'b1);
		rchk(`SPC_OFF_CTRL1, 8'hc0);
		tb_ss_n <= 1'b1;
		apb(1'b1, `SPC_OFF_STAT, 8'h10);
		apb(1'b1, `SPC_OFF_CTRL1, 8'h58);
		tick(3);
		chk(sck_o, 1'b1);
		// master bytes in both phases
		for (int m = 0; m < 2; m++) begin
			clock_phase <= m[0];
			far_tx <= 8'h3c + 8'(m);
			apb(1'b1, `SPC_OFF_CTRL1, 8'hd2 | {5'h0, m[0], 2'h0});
			apb(1'b1, `SPC_OFF_DATA, 8'ha5);
			wirq();
			chk(far_rx, 8'ha5);
			rchk(`SPC_OFF_DATA, 8'h3c + 8'(m));
			tick(2);
			chk(irq, 1'b0);
			chk(ss_w, 1'b1);
		end
		// disable in mid-byte
		apb(1'b1, `SPC_OFF_DATA, 8'h77);
		tick(20);
		apb(1'b1, `SPC_OFF_CTRL1, 8'h12);
		tick(3);
		rchk(`SPC_OFF_STAT, 8'h20);
		chk(pins, 8'h00);
		// event mask, clear, and transmit-empty interrupt
		apb(1'b1, `SPC_OFF_MASK, 8'h01);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, `SPC_OFF_EVT, 8'h07);
		tick(2);
		chk(irq, 1'b0);
		apb(1'b1, `SPC_OFF_MASK, 8'h00);
		apb(1'b1, `SPC_OFF_CTRL1, 8'h20);
		tick(2);
		chk(irq, 1'b1);
		apb(1'b1, `SPC_OFF_CTRL1, 8'h00);
		tick(2);
		chk(irq, 1'b0);
		// slave byte clocked by the far master at 160 ns
		apb(1'b1, `SPC_OFF_CTRL1, 8'hc0);
		apb(1'b1, `SPC_OFF_DATA, 8'h5a);
		tb_ss_n <= 1'b0;
		tick(8);
		for (int i = 7; i >= 0; i--) begin
			tb_mosi <= 1'(8'h96 >> i);
			tick(4);
			// far master takes the slave's bit at its leading edge
			sl_rx = {sl_rx[6:0], miso_w};
			tb_sck <= 1'b1;
			tick(4);
			tb_sck <= 1'b0;
		end
		wirq();
		chk(sl_rx, 8'h5a);
		tb_ss_n <= 1'b1;
		tb_mosi <= ~tb_mosi;
		rchk(`SPC_OFF_DATA, 8'h96);
		test_done();
	end
endmodule : spi_pin_control_and_config_tb_top
